// >>> tb/sio_exec_props.sv
// port-level assertions for the execution unit
`timescale 1ns/100ps
`default_nettype none
module sio_exec_props (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic ARST_N_I,
   // request
   input wire logic START_I,
   input wire sio_pkg::sio_op_t OP_I,
   input wire logic BUSY_O,
   input wire logic DONE_O,
   // registers
   input wire logic [7:0] ACC_O,
   input wire logic [7:0] FLAGS_O,
   input wire logic [15:0] HL_O,
   input wire logic [15:0] SP_O,
   // bus
   input wire logic ALE_O,
   input wire logic IO_M_O,
   input wire logic [7:0] DATA_O,
   input wire logic DATA_OE_O,
   input wire logic HALTED_O,
   // interrupts
   input wire logic RST75_I,
   input wire logic SERIAL_OUT_O,
   input wire logic INT_ENABLE_O,
   input wire logic [2:0] MASK_O,
   input wire logic PEND75_O
);
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!ARST_N_I);
   wire tk = START_I && !BUSY_O;
   property p_dis;
      tk && OP_I == sio_pkg::OP_INTERRUPT_DISABLE |-> !DONE_O[*4] ##1 DONE_O ##1 !INT_ENABLE_O;
   endproperty
   a_dis: assert property (p_dis) else $error("disable timing wrong");
   property p_halt;
      tk && OP_I == sio_pkg::OP_HALT |-> ##1 ALE_O ##3 ALE_O ##1 DONE_O ##1 HALTED_O;
   endproperty
   a_halt: assert property (p_halt) else $error("halt strobes wrong");
   property p_serial;
      tk && OP_I == sio_pkg::OP_SET_INTERRUPT_MASK && ACC_O[6]
         |-> ##5 SERIAL_OUT_O == $past(ACC_O[7], 5);
   endproperty
   a_serial: assert property (p_serial) else $error("serial latch wrong");
   property p_mask;
      tk && OP_I == sio_pkg::OP_SET_INTERRUPT_MASK && ACC_O[3] |-> ##5 MASK_O == $past(ACC_O[2:0], 5);
   endproperty
   a_mask: assert property (p_mask) else $error("mask load wrong");
   property p_pend;
      $rose(RST75_I) |-> ##[1:2] PEND75_O;
   endproperty
   a_pend: assert property (p_pend) else $error("edge latch not set");
   property p_flags;
      tk && OP_I != sio_pkg::OP_POP_FLAG_ACC_WORD |=> $stable(FLAGS_O)[*4];
   endproperty
   a_flags: assert property (p_flags) else $error("flags changed");
   property p_ldsp;
      tk && OP_I == sio_pkg::OP_LOAD_STACK_POINTER |-> ##7 SP_O == $past(HL_O, 7);
   endproperty
   a_ldsp: assert property (p_ldsp) else $error("stack pointer load wrong");
   property p_out;
      DATA_OE_O && IO_M_O |-> DATA_O == ACC_O;
   endproperty
   a_out: assert property (p_out) else $error("port data wrong");
endmodule
bind sio_exec sio_exec_props u_props (.SYS_CLK_I, .ARST_N_I, .START_I, .OP_I, .BUSY_O,
   .DONE_O, .ACC_O, .FLAGS_O, .HL_O, .SP_O, .ALE_O, .IO_M_O, .DATA_O, .DATA_OE_O,
   .HALTED_O, .RST75_I, .SERIAL_OUT_O, .INT_ENABLE_O, .MASK_O, .PEND75_O);
`default_nettype wire

// >>> tb/sio_mem_model.sv
// memory and port partner on the processor bus
`timescale 1ns/100ps
`default_nettype none
module sio_mem_model (
   // bus from the execution unit
   input wire logic clk_i,
   input wire logic [15:0] addr_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic io_m_i,
   input wire logic oe_i,
   input wire logic [7:0] wdata_i,
   // read data back
   output logic [7:0] rdata_o
);
   logic [7:0] store [0:255];
   logic [7:0] out_q;
   logic [7:0] last;
   initial
   begin
      for (int i = 0; i < 256; i++)
         store[i] = 8'(i) ^ 8'hA5;
      last = 8'h00;
      out_q = 8'h00;
   end
   // idle bus shows inverse of last byte, not a stale copy
   assign rdata_o = rd_n_i ? ~last : (io_m_i ? addr_i[7:0] ^ 8'h5A : store[addr_i[7:0]]);
   // no acknowledge answers at all, so never an enable or disable code
   always @(posedge clk_i)
   begin
      if (!rd_n_i)
         last <= rdata_o;
      if (!wr_n_i && oe_i && io_m_i)
         out_q <= wdata_i;
      if (!wr_n_i && oe_i && !io_m_i)
         store[addr_i[7:0]] <= wdata_i;
   end
endmodule
`default_nettype wire

// >>> tb/test_sio_exec.sv
// self-checking bench for the stack, port and control execution unit
`timescale 1ns/100ps
`default_nettype none
module test_sio_exec;
   logic SYS_CLK_I = 1'b0;
   logic ARST_N_I = 1'b0;
   logic START_I = 1'b0;
   sio_pkg::sio_op_t OP_I = sio_pkg::OP_NO_OPERATION;
   logic [1:0] RP_I = 2'h0;
   logic [7:0] PORT_I = 8'h3C;
   logic PRESET_I = 1'b0;
   logic [3:0] PRESET_SEL_I = 4'h0;
   logic [15:0] PRESET_DATA_I = 16'h0000;
   logic RST55_I = 1'b0;
   logic RST65_I = 1'b0;
   logic RST75_I = 1'b0;
   logic TRAP_TAKEN_I = 1'b0;
   logic ACK75_I = 1'b0;
   logic WAKE_I = 1'b0;
   logic SID_I = 1'b0;
   logic BUSY_O, DONE_O, ALE_O, RD_N_O, WR_N_O, IO_M_O, DATA_OE_O, HALTED_O;
   logic SERIAL_OUT_O, INT_ENABLE_O, INT_REQ_O, PEND75_O;
   logic [7:0] ACC_O, FLAGS_O, DATA_I, DATA_O;
   logic [15:0] BC_O, DE_O, HL_O, SP_O, PC_O, ADDR_O;
   logic [2:0] MASK_O;
   int fails = 0;
   int checks_done = 0;
   always #4 SYS_CLK_I = ~SYS_CLK_I;
   sio_exec dut (.SYS_CLK_I, .ARST_N_I, .START_I, .OP_I, .RP_I, .PORT_I, .BUSY_O, .DONE_O,
      .PRESET_I, .PRESET_SEL_I, .PRESET_DATA_I, .ACC_O, .FLAGS_O, .BC_O, .DE_O, .HL_O,
      .SP_O, .PC_O, .ADDR_O, .ALE_O, .RD_N_O, .WR_N_O, .IO_M_O, .DATA_I, .DATA_O,
      .DATA_OE_O, .HALTED_O, .RST55_I, .RST65_I, .RST75_I, .TRAP_TAKEN_I, .ACK75_I,
      .WAKE_I, .SID_I, .SERIAL_OUT_O, .INT_ENABLE_O, .INT_REQ_O, .MASK_O, .PEND75_O);
   sio_mem_model mem (.clk_i(SYS_CLK_I), .addr_i(ADDR_O), .rd_n_i(RD_N_O), .wr_n_i(WR_N_O),
      .io_m_i(IO_M_O), .oe_i(DATA_OE_O), .wdata_i(DATA_O), .rdata_o(DATA_I));
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // inputs always move 1 ns after the rising edge
   task automatic tick;
      @(posedge SYS_CLK_I);
      #1;
   endtask
   task automatic preset(input logic [3:0] sel, input logic [15:0] d);
      PRESET_I = 1'b1;
      PRESET_SEL_I = sel;
      PRESET_DATA_I = d;
      tick;
      PRESET_I = 1'b0;
   endtask
   // returns one cycle after done, so the next start is back to back
   task automatic run_op(input sio_pkg::sio_op_t op, input logic [1:0] rp, input int n);
      int i;
      OP_I = op;
      RP_I = rp;
      START_I = 1'b1;
      tick;
      START_I = 1'b0;
      i = 0;
      while (DONE_O !== 1'b1 && i < 40)
      begin
         tick;
         i++;
      end
      if (i == 40)
      begin
         fails++;
         give_verdict;
      end
      else
      begin
         chk(16'(i + 1), 16'(n));
         tick;
      end
   endtask
   initial
   begin
      repeat (4) @(posedge SYS_CLK_I);
      #1;
      ARST_N_I = 1'b1;
      chk({12'h000, MASK_O, SERIAL_OUT_O}, 16'h000E);
      preset(4'h0, 16'h0012);
      preset(4'h1, 16'h0034);
      preset(4'h8, 16'h0080);
      run_op(sio_pkg::OP_PUSH_PAIR, 2'h0, 12);
      chk({mem.store[8'h7F], mem.store[8'h7E]}, 16'h1234);
      chk(SP_O, 16'h007E);
      preset(4'h6, 16'h00FF);
      preset(4'h7, 16'h005A);
      run_op(sio_pkg::OP_PUSH_FLAG_ACC_WORD, 2'h0, 12);
      chk({mem.store[8'h7D], mem.store[8'h7C] & 8'hD5}, 16'h5AD5);
      run_op(sio_pkg::OP_POP_PAIR, 2'h1, 10);
      chk(DE_O, {8'h5A, mem.store[8'h7C]});
      run_op(sio_pkg::OP_POP_FLAG_ACC_WORD, 2'h0, 10);
      chk({ACC_O, FLAGS_O}, 16'h1214);
      chk(SP_O, 16'h0080);
      preset(4'h4, 16'h00AB);
      preset(4'h5, 16'h00CD);
      run_op(sio_pkg::OP_STACK_TOP_EXCHANGE, 2'h0, 16);
      chk(HL_O, 16'h2425);
      chk({mem.store[8'h81], mem.store[8'h80]}, 16'hABCD);
      run_op(sio_pkg::OP_LOAD_STACK_POINTER, 2'h0, 6);
      run_op(sio_pkg::OP_JUMP_VIA_POINTER_PAIR, 2'h0, 6);
      chk(PC_O, 16'h2425);
      run_op(sio_pkg::OP_PORT_OUT, 2'h0, 10);
      chk({8'h00, mem.out_q}, 16'h0012);
      run_op(sio_pkg::OP_PORT_IN, 2'h0, 10);
      chk({ACC_O, FLAGS_O}, 16'h6614);
      chk(ADDR_O, 16'h3C3C);
      run_op(sio_pkg::OP_INTERRUPT_ENABLE, 2'h0, 4);
      chk({15'h0000, INT_ENABLE_O}, 16'h0000);
      run_op(sio_pkg::OP_NO_OPERATION, 2'h0, 4);
      chk({15'h0000, INT_ENABLE_O}, 16'h0001);
      SID_I = 1'b1;
      RST55_I = 1'b1;
      TRAP_TAKEN_I = 1'b1;
      tick;
      TRAP_TAKEN_I = 1'b0;
      run_op(sio_pkg::OP_READ_INTERRUPT_MASK, 2'h0, 4);
      chk({8'h00, ACC_O}, 16'h009F);
      run_op(sio_pkg::OP_READ_INTERRUPT_MASK, 2'h0, 4);
      chk({8'h00, ACC_O}, 16'h0097);
      run_op(sio_pkg::OP_INTERRUPT_DISABLE, 2'h0, 4);
      RST75_I = 1'b1;
      tick;
      tick;
      RST75_I = 1'b0;
      run_op(sio_pkg::OP_READ_INTERRUPT_MASK, 2'h0, 4);
      chk({8'h00, ACC_O}, 16'h00D7);
      preset(4'h7, 16'h00C8);
      run_op(sio_pkg::OP_SET_INTERRUPT_MASK, 2'h0, 4);
      chk({12'h000, MASK_O, SERIAL_OUT_O}, 16'h0001);
      chk({15'h0000, PEND75_O}, 16'h0001);
      preset(4'h7, 16'h0017);
      run_op(sio_pkg::OP_SET_INTERRUPT_MASK, 2'h0, 4);
      chk({11'h000, MASK_O, SERIAL_OUT_O, PEND75_O}, 16'h0002);
      RST75_I = 1'b1;
      tick;
      tick;
      RST75_I = 1'b0;
      chk({15'h0000, PEND75_O}, 16'h0001);
      ACK75_I = 1'b1;
      tick;
      ACK75_I = 1'b0;
      chk({15'h0000, PEND75_O}, 16'h0000);
      chk({15'h0000, INT_REQ_O}, 16'h0000);
      run_op(sio_pkg::OP_INTERRUPT_ENABLE, 2'h0, 4);
      run_op(sio_pkg::OP_NO_OPERATION, 2'h0, 4);
      chk({15'h0000, INT_REQ_O}, 16'h0001);
      run_op(sio_pkg::OP_HALT, 2'h0, 5);
      chk({7'h00, HALTED_O, ACC_O}, 16'h0117);
      WAKE_I = 1'b1;
      tick;
      WAKE_I = 1'b0;
      tick;
      chk({15'h0000, HALTED_O}, 16'h0000);
      give_verdict;
   end
endmodule
`default_nettype wire

// >>> verilog/sio_exec.sv
// execution unit for the stack, port i/o and machine-control operations
`timescale 1ns/100ps
`default_nettype none
module sio_exec (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic ARST_N_I,
   // operation request
   input wire logic START_I,
   input wire sio_pkg::sio_op_t OP_I,
   input wire logic [1:0] RP_I,
   input wire logic [7:0] PORT_I,
   output logic BUSY_O,
   output logic DONE_O,
   // register preset and view
   input wire logic PRESET_I,
   input wire logic [3:0] PRESET_SEL_I,
   input wire logic [15:0] PRESET_DATA_I,
   output logic [7:0] ACC_O,
   output logic [7:0] FLAGS_O,
   output logic [15:0] BC_O,
   output logic [15:0] DE_O,
   output logic [15:0] HL_O,
   output logic [15:0] SP_O,
   output logic [15:0] PC_O,
   // processor bus
   output logic [15:0] ADDR_O,
   output logic ALE_O,
   output logic RD_N_O,
   output logic WR_N_O,
   output logic IO_M_O,
   input wire logic [7:0] DATA_I,
   output logic [7:0] DATA_O,
   output logic DATA_OE_O,
   output logic HALTED_O,
   // interrupts and serial lines
   input wire logic RST55_I,
   input wire logic RST65_I,
   input wire logic RST75_I,
   input wire logic TRAP_TAKEN_I,
   input wire logic ACK75_I,
   input wire logic WAKE_I,
   input wire logic SID_I,
   output logic SERIAL_OUT_O,
   output logic INT_ENABLE_O,
   output logic INT_REQ_O,
   output logic [2:0] MASK_O,
   output logic PEND75_O
);

   function automatic logic [4:0] op_states(input sio_pkg::sio_op_t op);
      case (op)
         sio_pkg::OP_JUMP_VIA_POINTER_PAIR: op_states = sio_pkg::STATES_JUMP;
         sio_pkg::OP_PUSH_PAIR: op_states = sio_pkg::STATES_PUSH;
         sio_pkg::OP_PUSH_FLAG_ACC_WORD: op_states = sio_pkg::STATES_PUSH;
         sio_pkg::OP_POP_PAIR: op_states = sio_pkg::STATES_POP;
         sio_pkg::OP_POP_FLAG_ACC_WORD: op_states = sio_pkg::STATES_POP;
         sio_pkg::OP_STACK_TOP_EXCHANGE: op_states = sio_pkg::STATES_EXCHANGE;
         sio_pkg::OP_LOAD_STACK_POINTER: op_states = sio_pkg::STATES_LOAD_SP;
         sio_pkg::OP_PORT_IN: op_states = sio_pkg::STATES_PORT;
         sio_pkg::OP_PORT_OUT: op_states = sio_pkg::STATES_PORT;
         sio_pkg::OP_HALT: op_states = sio_pkg::STATES_HALT;
         default: op_states = sio_pkg::STATES_SHORT;
      endcase
   endfunction

   function automatic logic [4:0] first_acc(input sio_pkg::sio_op_t op);
      case (op)
         sio_pkg::OP_PUSH_PAIR: first_acc = sio_pkg::FIRST_ACC_PUSH;
         sio_pkg::OP_PUSH_FLAG_ACC_WORD: first_acc = sio_pkg::FIRST_ACC_PUSH;
         sio_pkg::OP_POP_PAIR: first_acc = sio_pkg::FIRST_ACC_POP;
         sio_pkg::OP_POP_FLAG_ACC_WORD: first_acc = sio_pkg::FIRST_ACC_POP;
         sio_pkg::OP_STACK_TOP_EXCHANGE: first_acc = sio_pkg::FIRST_ACC_EXCHANGE;
         default: first_acc = sio_pkg::FIRST_ACC_PORT;
      endcase
   endfunction

   function automatic logic [4:0] acc_span(input sio_pkg::sio_op_t op);
      case (op)
         sio_pkg::OP_PUSH_PAIR,
         sio_pkg::OP_PUSH_FLAG_ACC_WORD:
            acc_span = 5'(sio_pkg::BUS_PHASES * sio_pkg::ACC_COUNT_PUSH);
         sio_pkg::OP_POP_PAIR,
         sio_pkg::OP_POP_FLAG_ACC_WORD:
            acc_span = 5'(sio_pkg::BUS_PHASES * sio_pkg::ACC_COUNT_POP);
         sio_pkg::OP_STACK_TOP_EXCHANGE:
            acc_span = 5'(sio_pkg::BUS_PHASES * sio_pkg::ACC_COUNT_EXCHANGE);
         sio_pkg::OP_PORT_IN,
         sio_pkg::OP_PORT_OUT:
            acc_span = 5'(sio_pkg::BUS_PHASES * sio_pkg::ACC_COUNT_PORT);
         default: acc_span = 5'h00;
      endcase
   endfunction

   // control state
   sio_pkg::sio_state_t state_r;
   sio_pkg::sio_state_t state_nxt;
   sio_pkg::sio_op_t op_r;
   logic [1:0] rp_r;
   logic [7:0] port_r;
   logic [4:0] t_r;
   logic [4:0] t_nxt;

   // architectural registers
   logic [7:0] gpr_r [0:7];
   logic [7:0] gpr_nxt [0:7];
   logic [15:0] sp_r;
   logic [15:0] sp_nxt;
   logic [15:0] pc_r;
   logic [15:0] pc_nxt;

   // bus registers
   logic [15:0] addr_r;
   logic [15:0] addr_nxt;
   logic ale_r;
   logic ale_nxt;
   logic rd_r;
   logic rd_nxt;
   logic wr_r;
   logic wr_nxt;
   logic iom_r;
   logic iom_nxt;
   logic doe_r;
   logic doe_nxt;
   logic [7:0] dout_r;
   logic [7:0] dout_nxt;
   logic cap_r;
   logic cap_nxt;
   logic cap_hi_r;
   logic cap_hi_nxt;
   logic [7:0] rd_lo_r;
   logic [7:0] rd_hi_r;

   // interrupt state
   logic ie_r;
   logic ie_nxt;
   logic en_arm_r;
   logic en_arm_nxt;
   logic trap_r;
   logic ie_saved_r;
   logic [2:0] mask_r;
   logic [2:0] mask_nxt;
   logic r75_r;
   logic r75_prev_r;
   logic ser_out_r;
   logic ser_out_nxt;

   wire start_ok = START_I && (state_r == sio_pkg::ST_IDLE);
   wire in_exec = (state_r == sio_pkg::ST_EXEC);
   wire last = in_exec && (t_r == op_states(op_r) - 5'h01);
   wire exec_nxt = start_ok || (in_exec && !last);
   wire sio_pkg::sio_op_t op_cur = start_ok ? OP_I : op_r;
   wire [1:0] rp_cur = start_ok ? RP_I : rp_r;
   wire [7:0] port_cur = start_ok ? PORT_I : port_r;
   wire [7:0] acc = gpr_r[sio_pkg::REG_ACC];
   wire [15:0] hl = {gpr_r[sio_pkg::REG_H], gpr_r[sio_pkg::REG_L]};

   // access schedule for the state about to be entered
   wire [4:0] fa = first_acc(op_cur);
   wire [4:0] rel = t_nxt - fa;
   wire in_acc = exec_nxt && (t_nxt >= fa) && (rel < acc_span(op_cur));
   wire [2:0] acc_j = 3'(rel / 5'(sio_pkg::BUS_PHASES));
   wire [1:0] acc_ph = 2'(rel % 5'(sio_pkg::BUS_PHASES));
   wire is_push = (op_cur == sio_pkg::OP_PUSH_PAIR)
      || (op_cur == sio_pkg::OP_PUSH_FLAG_ACC_WORD);
   wire is_port = (op_cur == sio_pkg::OP_PORT_IN) || (op_cur == sio_pkg::OP_PORT_OUT);
   wire acc_write = is_push || (op_cur == sio_pkg::OP_PORT_OUT)
      || ((op_cur == sio_pkg::OP_STACK_TOP_EXCHANGE) && acc_j[1]);
   wire [15:0] push_addr = (acc_j == 3'h0) ? sp_r - 16'h0001 : sp_r - 16'h0002;
   wire [15:0] stack_addr = acc_j[0] ? sp_r + 16'h0001 : sp_r;
   wire [15:0] acc_addr = is_port ? {port_cur, port_cur}
      : (is_push ? push_addr : stack_addr);
   wire [7:0] pair_hi = gpr_r[{rp_cur, 1'b0}];
   wire [7:0] pair_lo = gpr_r[{rp_cur, 1'b1}];
   wire [7:0] word_lo = gpr_r[sio_pkg::REG_FLAGS] & sio_pkg::FLAG_DEFINED_MASK;
   wire [7:0] push_data = (op_cur == sio_pkg::OP_PUSH_PAIR)
      ? ((acc_j == 3'h0) ? pair_hi : pair_lo)
      : ((acc_j == 3'h0) ? acc : word_lo);
   wire [7:0] xchg_data = acc_j[0] ? gpr_r[sio_pkg::REG_H] : gpr_r[sio_pkg::REG_L];
   wire [7:0] acc_wdata = is_push ? push_data : (is_port ? acc : xchg_data);
   wire halt_strobe = exec_nxt && (op_cur == sio_pkg::OP_HALT)
      && ((t_nxt == 5'h00) || (t_nxt == sio_pkg::HALT_STATUS_STROBE_STATE));

   // read data of the final state is used straight from the bus
   wire [7:0] rd_lo = (cap_r && !cap_hi_r) ? DATA_I : rd_lo_r;
   wire [7:0] rd_hi = (cap_r && cap_hi_r) ? DATA_I : rd_hi_r;

   // interrupt view
   wire [2:0] pend = {r75_r, RST65_I, RST55_I};
   wire ie_view = trap_r ? ie_saved_r : ie_r;
   wire [7:0] mask_read_val = {SID_I, pend, ie_view, mask_r};
   wire r75_edge = RST75_I && !r75_prev_r;
   wire mask_set_now = last && (op_r == sio_pkg::OP_SET_INTERRUPT_MASK);
   wire en_dis_running = in_exec && ((op_r == sio_pkg::OP_INTERRUPT_ENABLE)
      || (op_r == sio_pkg::OP_INTERRUPT_DISABLE));

   always_comb
   begin
      t_nxt = 5'h00;
      if (start_ok)
      begin
         t_nxt = 5'h00;
      end
      else if (in_exec && !last)
      begin
         t_nxt = t_r + 5'h01;
      end
      state_nxt = state_r;
      case (state_r)
         sio_pkg::ST_IDLE:
            if (start_ok)
            begin
               state_nxt = sio_pkg::ST_EXEC;
            end
         sio_pkg::ST_EXEC:
            if (last)
            begin
               state_nxt = (op_r == sio_pkg::OP_HALT) ? sio_pkg::ST_HALTED
                  : sio_pkg::ST_IDLE;
            end
         sio_pkg::ST_HALTED:
            if (WAKE_I)
            begin
               state_nxt = sio_pkg::ST_IDLE;
            end
         default: state_nxt = sio_pkg::ST_IDLE;
      endcase
   end

   // bus phases: 0 address strobe, 1-2 read or write strobe, read taken in 2
   always_comb
   begin
      ale_nxt = (in_acc && (acc_ph == 2'h0)) || halt_strobe;
      rd_nxt = in_acc && (acc_ph != 2'h0) && !acc_write;
      wr_nxt = in_acc && (acc_ph != 2'h0) && acc_write;
      doe_nxt = wr_nxt;
      dout_nxt = wr_nxt ? acc_wdata : 8'h00;
      addr_nxt = in_acc ? acc_addr : addr_r;
      iom_nxt = in_acc ? is_port : iom_r;
      cap_nxt = rd_nxt && (acc_ph == 2'h2);
      cap_hi_nxt = acc_j[0];
   end

   // register file; only a preset, a flag/accumulator word pop or a pair pop of pair 3 writes flags
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         gpr_nxt[i] = gpr_r[i];
      end
      sp_nxt = sp_r;
      pc_nxt = pc_r;
      if (PRESET_I && (state_r == sio_pkg::ST_IDLE) && !START_I)
      begin
         if (PRESET_SEL_I == sio_pkg::PRESET_SEL_SP)
         begin
            sp_nxt = PRESET_DATA_I;
         end
         else if (PRESET_SEL_I == sio_pkg::PRESET_SEL_PC)
         begin
            pc_nxt = PRESET_DATA_I;
         end
         else if (!PRESET_SEL_I[3])
         begin
            gpr_nxt[PRESET_SEL_I[2:0]] = PRESET_DATA_I[7:0];
         end
      end
      if (last)
      begin
         case (op_r)
            sio_pkg::OP_JUMP_VIA_POINTER_PAIR: pc_nxt = hl;
            sio_pkg::OP_PUSH_PAIR,
            sio_pkg::OP_PUSH_FLAG_ACC_WORD: sp_nxt = sp_r - 16'h0002;
            sio_pkg::OP_POP_PAIR:
            begin
               gpr_nxt[{rp_r, 1'b1}] = rd_lo;
               gpr_nxt[{rp_r, 1'b0}] = rd_hi;
               sp_nxt = sp_r + 16'h0002;
            end
            sio_pkg::OP_POP_FLAG_ACC_WORD:
            begin
               gpr_nxt[sio_pkg::REG_FLAGS] = rd_lo & sio_pkg::FLAG_DEFINED_MASK;
               gpr_nxt[sio_pkg::REG_ACC] = rd_hi;
               sp_nxt = sp_r + 16'h0002;
            end
            sio_pkg::OP_STACK_TOP_EXCHANGE:
            begin
               gpr_nxt[sio_pkg::REG_L] = rd_lo;
               gpr_nxt[sio_pkg::REG_H] = rd_hi;
            end
            sio_pkg::OP_LOAD_STACK_POINTER: sp_nxt = hl;
            sio_pkg::OP_PORT_IN: gpr_nxt[sio_pkg::REG_ACC] = rd_lo;
            sio_pkg::OP_READ_INTERRUPT_MASK: gpr_nxt[sio_pkg::REG_ACC] = mask_read_val;
            default: pc_nxt = pc_r;
         endcase
      end
   end

   // enable waits for the next completed operation; a trap parks the old state
   always_comb
   begin
      ie_nxt = ie_r;
      en_arm_nxt = en_arm_r;
      if (last)
      begin
         if (op_r == sio_pkg::OP_INTERRUPT_ENABLE)
         begin
            en_arm_nxt = 1'b1;
         end
         else if (op_r == sio_pkg::OP_INTERRUPT_DISABLE)
         begin
            ie_nxt = 1'b0;
            en_arm_nxt = 1'b0;
         end
         else if (en_arm_r)
         begin
            ie_nxt = 1'b1;
            en_arm_nxt = 1'b0;
         end
      end
      if (TRAP_TAKEN_I)
      begin
         ie_nxt = 1'b0;
         en_arm_nxt = 1'b0;
      end
      mask_nxt = (mask_set_now && acc[sio_pkg::MASKSET_LOAD_BIT]) ? acc[2:0] : mask_r;
      ser_out_nxt = (mask_set_now && acc[sio_pkg::MASKSET_SERIAL_ENABLE_BIT])
         ? acc[sio_pkg::MASKSET_SERIAL_DATA_BIT] : ser_out_r;
   end

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         state_r <= sio_pkg::ST_IDLE;
         op_r <= sio_pkg::OP_NO_OPERATION;
         rp_r <= 2'h0;
         port_r <= 8'h00;
         t_r <= 5'h00;
         sp_r <= sio_pkg::PTR_RESET;
         pc_r <= sio_pkg::PTR_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         op_r <= op_cur;
         rp_r <= rp_cur;
         port_r <= port_cur;
         t_r <= t_nxt;
         sp_r <= sp_nxt;
         pc_r <= pc_nxt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : gen_gpr
         always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
         begin
            if (!ARST_N_I)
            begin
               gpr_r[g] <= sio_pkg::REG_RESET;
            end
            else
            begin
               gpr_r[g] <= gpr_nxt[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         addr_r <= 16'h0000;
         ale_r <= 1'b0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         iom_r <= 1'b0;
         doe_r <= 1'b0;
         dout_r <= 8'h00;
         cap_r <= 1'b0;
         cap_hi_r <= 1'b0;
         rd_lo_r <= 8'h00;
         rd_hi_r <= 8'h00;
      end
      else
      begin
         addr_r <= addr_nxt;
         ale_r <= ale_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         iom_r <= iom_nxt;
         doe_r <= doe_nxt;
         dout_r <= dout_nxt;
         cap_r <= cap_nxt;
         cap_hi_r <= cap_hi_nxt;
         rd_lo_r <= rd_lo;
         rd_hi_r <= rd_hi;
      end
   end

   // the edge latch: a new edge beats any clear in the same cycle
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         r75_r <= 1'b0;
         r75_prev_r <= 1'b0;
      end
      else
      begin
         r75_prev_r <= RST75_I;
         if (r75_edge)
         begin
            r75_r <= 1'b1;
         end
         else if (mask_set_now && acc[sio_pkg::MASKSET_CLEAR_R75_BIT])
         begin
            r75_r <= 1'b0;
         end
         else if (ACK75_I && !mask_r[2])
         begin
            r75_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         ie_r <= 1'b0;
         en_arm_r <= 1'b0;
         trap_r <= 1'b0;
         ie_saved_r <= 1'b0;
         mask_r <= sio_pkg::MASK_RESET;
         ser_out_r <= sio_pkg::SERIAL_OUT_RESET;
      end
      else
      begin
         ie_r <= ie_nxt;
         en_arm_r <= en_arm_nxt;
         // trap marker lives until the first operation after it completes
         if (TRAP_TAKEN_I)
         begin
            trap_r <= 1'b1;
            ie_saved_r <= ie_r;
         end
         else if (last)
         begin
            trap_r <= 1'b0;
         end
         mask_r <= mask_nxt;
         ser_out_r <= ser_out_nxt;
      end
   end

   assign BUSY_O = (state_r != sio_pkg::ST_IDLE);
   assign DONE_O = last;
   assign ACC_O = acc;
   assign FLAGS_O = gpr_r[sio_pkg::REG_FLAGS];
   assign BC_O = {gpr_r[0], gpr_r[1]};
   assign DE_O = {gpr_r[2], gpr_r[3]};
   assign HL_O = hl;
   assign SP_O = sp_r;
   assign PC_O = pc_r;
   assign ADDR_O = addr_r;
   assign ALE_O = ale_r;
   assign RD_N_O = !rd_r;
   assign WR_N_O = !wr_r;
   assign IO_M_O = iom_r;
   assign DATA_O = dout_r;
   assign DATA_OE_O = doe_r;
   assign HALTED_O = (state_r == sio_pkg::ST_HALTED);
   assign SERIAL_OUT_O = ser_out_r;
   assign INT_ENABLE_O = ie_r;
   assign MASK_O = mask_r;
   assign PEND75_O = r75_r;
   // no request is raised while an enable or disable is running
   assign INT_REQ_O = ie_r && !en_dis_running && |(pend & ~mask_r);

endmodule
`default_nettype wire

// >>> verilog/sio_pkg.sv
// constants and types shared by the stack, i/o and machine-control execution block
package sio_pkg;

   typedef enum logic [3:0] {
      OP_JUMP_VIA_POINTER_PAIR = 4'h0,
      OP_PUSH_PAIR = 4'h1,
      OP_PUSH_FLAG_ACC_WORD = 4'h2,
      OP_POP_PAIR = 4'h3,
      OP_POP_FLAG_ACC_WORD = 4'h4,
      OP_STACK_TOP_EXCHANGE = 4'h5,
      OP_LOAD_STACK_POINTER = 4'h6,
      OP_PORT_IN = 4'h7,
      OP_PORT_OUT = 4'h8,
      OP_INTERRUPT_ENABLE = 4'h9,
      OP_INTERRUPT_DISABLE = 4'hA,
      OP_HALT = 4'hB,
      OP_NO_OPERATION = 4'hC,
      OP_READ_INTERRUPT_MASK = 4'hD,
      OP_SET_INTERRUPT_MASK = 4'hE
   } sio_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_HALTED = 2'b10
   } sio_state_t;

   // processor states per operation, one clock each
   localparam logic [4:0] STATES_JUMP = 5'h06;
   localparam logic [4:0] STATES_PUSH = 5'h0C;
   localparam logic [4:0] STATES_POP = 5'h0A;
   localparam logic [4:0] STATES_EXCHANGE = 5'h10;
   localparam logic [4:0] STATES_LOAD_SP = 5'h06;
   localparam logic [4:0] STATES_PORT = 5'h0A;
   localparam logic [4:0] STATES_SHORT = 5'h04;
   localparam logic [4:0] STATES_HALT = 5'h05;

   // bus access schedule: first state of first access, number of accesses
   localparam int BUS_PHASES = 3;
   localparam logic [4:0] FIRST_ACC_PUSH = 5'h06;
   localparam logic [4:0] FIRST_ACC_POP = 5'h04;
   localparam logic [4:0] FIRST_ACC_EXCHANGE = 5'h04;
   localparam logic [4:0] FIRST_ACC_PORT = 5'h07;
   localparam int ACC_COUNT_PUSH = 2;
   localparam int ACC_COUNT_POP = 2;
   localparam int ACC_COUNT_EXCHANGE = 4;
   localparam int ACC_COUNT_PORT = 1;
   localparam logic [4:0] HALT_STATUS_STROBE_STATE = 5'h03;

   // register file indexes; pair n is (2n, 2n+1)
   localparam logic [2:0] REG_H = 3'h4;
   localparam logic [2:0] REG_L = 3'h5;
   localparam logic [2:0] REG_FLAGS = 3'h6;
   localparam logic [2:0] REG_ACC = 3'h7;
   localparam logic [3:0] PRESET_SEL_SP = 4'h8;
   localparam logic [3:0] PRESET_SEL_PC = 4'h9;

   // flag byte layout; undefined positions zeroed on flag/accumulator word push and pop
   localparam logic [7:0] FLAG_DEFINED_MASK = 8'hD5;

   // read-interrupt-mask result layout
   localparam int MASKREAD_ENABLE_BIT = 3;

   // set-interrupt-mask accumulator fields
   localparam int MASKSET_LOAD_BIT = 3;
   localparam int MASKSET_CLEAR_R75_BIT = 4;
   localparam int MASKSET_SERIAL_ENABLE_BIT = 6;
   localparam int MASKSET_SERIAL_DATA_BIT = 7;

   // values after reset
   localparam logic [2:0] MASK_RESET = 3'h7;
   localparam logic SERIAL_OUT_RESET = 1'b0;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [7:0] REG_RESET = 8'h00;

endpackage
